// ---- common/adc_cal_regs.svh ----
// Configuration word layout, reset values and sequencing counts
`ifndef ADC_CAL_REGS_SVH
`define ADC_CAL_REGS_SVH

// Word sizes of the serial port
`define WORD_BITS         24
`define COUNT_FULL_WORD   5'd24
`define COUNT_SHORT_WORD  5'd16
`define COUNT_ZERO        5'd0
`define COUNT_ONE         5'd1

// Configuration word fields, bit 23 is first on the wire
`define CFG_MODE_HI       23
`define CFG_MODE_LO       21
`define CFG_GAIN_HI       20
`define CFG_GAIN_LO       18
`define CFG_CHAN_HI       17
`define CFG_CHAN_LO       16
`define CFG_WIDTH_BIT     15
`define CFG_EXCITE_BIT    14
`define CFG_BURNOUT_BIT   13
`define CFG_UNIPOLAR_BIT  12
`define CFG_FILTER_HI     11
`define CFG_FILTER_LO     0

// Reset values
`define CFG_RESET         24'h000000
`define COEF_RESET        24'h000000
`define DATA_RESET        24'h000000

// Background mode: measurements per output word
`define BG_SLOT_LAST      3'h5
`define BG_SLOT_FIRST     3'h0
`define BG_SLOT_STEP      3'h1

`endif

// ---- common/adc_cal_pkg.sv ----
// Types shared by the calibration and mode control block
package adc_cal_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL      = 3'h0,
    MODE_SELF_CAL    = 3'h1,
    MODE_SYS_ZERO    = 3'h2,
    MODE_SYS_FULL    = 3'h3,
    MODE_SYS_OFFSET  = 3'h4,
    MODE_BACKGROUND  = 3'h5,
    MODE_ZERO_ACCESS = 3'h6,
    MODE_FULL_ACCESS = 3'h7
  } op_mode_t;

  typedef enum logic [2:0] {
    MEAS_CONVERT     = 3'h0,
    MEAS_ZERO_SHORT  = 3'h1,
    MEAS_ZERO_INPUT  = 3'h2,
    MEAS_FULL_INPUT  = 3'h3,
    MEAS_FULL_REF    = 3'h4
  } meas_kind_t;

  // Gray order along idle, issue, wait, store
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ISSUE = 2'h1,
    ST_WAIT  = 2'h3,
    ST_STORE = 2'h2
  } seq_state_t;

  typedef struct packed {
    logic [23:0] cfg;
    logic [23:0] data_word;
    logic [23:0] result;
    logic        ready_n;
    seq_state_t  st;
    meas_kind_t  kind;
    logic [1:0]  chan;
    logic        step;
    logic [2:0]  bg_slot;
  } ctl_state_t;

  typedef struct packed {
    logic        sclk_q;
    logic        wf_q;
    logic        rf_q;
    logic [4:0]  wr_cnt;
    logic [23:0] wr_shift;
    logic        wr_target;
    logic        wr_valid;
    logic        rd_active;
    logic [23:0] rd_shift;
    logic [4:0]  rd_left;
    logic        rd_target;
    logic        rd_done;
  } ser_state_t;

endpackage

// ---- rtl/cal_serial_port.sv ----
// Serial frame engine: 24-bit write capture and MSB-first read shifter
`timescale 1ns/10ps
`include "adc_cal_regs.svh"
module cal_serial_port (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Serial pins
  input  wire logic        serial_clk,
  input  wire logic        write_frame_n,
  input  wire logic        read_frame_n,
  input  wire logic        register_target_select,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  // Word side
  input  wire logic [23:0] rd_word,
  input  wire logic        rd_len24,
  output logic             wr_valid,
  output logic [23:0]      wr_data,
  output logic             wr_target,
  output logic             rd_done,
  output logic             rd_target
);
  import adc_cal_pkg::*;

  ser_state_t s;
  ser_state_t next_s;
  logic       clk_rise;
  logic       clk_fall;

  assign clk_rise        = serial_clk & ~s.sclk_q;
  assign clk_fall        = ~serial_clk & s.sclk_q;
  assign serial_data_out = s.rd_shift[23];
  assign serial_data_oe  = s.rd_active & (s.rd_left != `COUNT_ZERO);
  assign wr_valid        = s.wr_valid;
  assign wr_data         = s.wr_shift;
  assign wr_target       = s.wr_target;
  assign rd_done         = s.rd_done;
  assign rd_target       = s.rd_target;

  always_comb begin
    next_s          = s;
    next_s.sclk_q   = serial_clk;
    next_s.wf_q     = write_frame_n;
    next_s.rf_q     = read_frame_n;
    next_s.wr_valid = 1'b0;
    next_s.rd_done  = 1'b0;
    if (!write_frame_n && s.wf_q) begin
      next_s.wr_cnt    = `COUNT_ZERO;
      next_s.wr_target = register_target_select;
    end else if (!write_frame_n && clk_rise && s.wr_cnt < `COUNT_FULL_WORD) begin
      next_s.wr_shift = {s.wr_shift[22:0], serial_data_in};
      next_s.wr_cnt   = s.wr_cnt + `COUNT_ONE;
    end
    if (write_frame_n && !s.wf_q) begin
      next_s.wr_valid = (s.wr_cnt == `COUNT_FULL_WORD);
      next_s.wr_cnt   = `COUNT_ZERO;
    end
    if (!read_frame_n && s.rf_q) begin
      next_s.rd_active = 1'b1;
      next_s.rd_shift  = rd_word;
      next_s.rd_left   = rd_len24 ? `COUNT_FULL_WORD : `COUNT_SHORT_WORD;
      next_s.rd_target = register_target_select;
    end else if (s.rd_active && clk_fall && s.rd_left != `COUNT_ZERO) begin
      next_s.rd_shift = {s.rd_shift[22:0], 1'b0};
      next_s.rd_left  = s.rd_left - `COUNT_ONE;
    end
    if (read_frame_n && !s.rf_q && s.rd_active) begin
      next_s.rd_active = 1'b0;
      next_s.rd_done   = (s.rd_left == `COUNT_ZERO);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s        <= '0;
      s.sclk_q <= 1'b0;
      s.wf_q   <= 1'b1;
      s.rf_q   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ---- rtl/cal_coef_store.sv ----
// Per-channel zero-scale and full-scale calibration coefficients
`timescale 1ns/10ps
`include "adc_cal_regs.svh"
module cal_coef_store #(
  parameter int CHANNELS = 3
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Write port
  input  wire logic        zero_we,
  input  wire logic        full_we,
  input  wire logic [1:0]  wr_ch,
  input  wire logic [23:0] wr_data,
  // Read port
  input  wire logic [1:0]  rd_ch,
  output logic [23:0]      rd_zero,
  output logic [23:0]      rd_full
);
  typedef struct packed {
    logic [CHANNELS-1:0][23:0] zero;
    logic [CHANNELS-1:0][23:0] full;
  } coef_state_t;

  coef_state_t s;
  coef_state_t next_s;

  generate
    if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad_channels
      $error("cal_coef_store: CHANNELS must be 1 to 4");
    end
  endgenerate

  // Codes past the last channel neither store nor read back
  always_comb begin
    next_s = s;
    if (int'(wr_ch) < CHANNELS) begin
      if (zero_we) begin
        next_s.zero[wr_ch] = wr_data;
      end
      if (full_we) begin
        next_s.full[wr_ch] = wr_data;
      end
    end
  end

  always_comb begin
    rd_zero = `COEF_RESET;
    rd_full = `COEF_RESET;
    if (int'(rd_ch) < CHANNELS) begin
      rd_zero = s.zero[rd_ch];
      rd_full = s.full[rd_ch];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ---- rtl/adc_calibration_mode_control.sv ----
// Configuration word decode and calibration sequencer of the converter
//
// Contract
// - System calibration step two: full-scale on chosen input, ready, back to normal.
// - System offset: zero from input, full from reference, ready, then normal.
// - Background mode interleaves shorted-zero and reference cals; word rate drops sixfold.
// - Background mode keeps updating the chosen channel's coefficients.
// - Zero-access mode maps target-high reads and writes to channel zero coefficient.
// - Full-access mode maps target-high reads and writes to channel full coefficient.
// - Coefficient transfers are always 24 bits; short writes are discarded.
// - Two-bit channel field picks one of three inputs; zero after reset.
// - Polarity bit: clear is bipolar, set is unipolar; bipolar after reset.
// - Mode resets to normal; normal target-high reads return the data word.
// - Configuration word loads only after 24 clocks; further clocks are ignored.
`timescale 1ns/10ps
`include "adc_cal_regs.svh"
module adc_calibration_mode_control #(
  parameter int CHANNELS = 3
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // Serial port
  input  wire logic                   serial_clk,
  input  wire logic                   write_frame_n,
  input  wire logic                   read_frame_n,
  input  wire logic                   register_target_select,
  input  wire logic                   serial_data_in,
  output logic                        serial_data_out,
  output logic                        serial_data_oe,
  output logic                        conversion_ready_n,
  // Measurement core handshake
  output logic                        meas_req,
  output adc_cal_pkg::meas_kind_t     meas_kind,
  output logic [1:0]                  meas_channel,
  input  wire logic                   meas_done,
  input  wire logic [23:0]            meas_value,
  // Front end settings
  output adc_cal_pkg::op_mode_t       op_mode,
  output logic                        channel_pick_bit0,
  output logic                        channel_pick_bit1,
  output logic [2:0]                  programmable_gain_amp,
  output logic [7:0]                  gain_factor,
  output logic                        output_width_bit,
  output logic                        excitation_current_enable,
  output logic                        burnout_current_enable,
  output logic                        unipolar_select,
  output logic [11:0]                 filter_code,
  output logic                        background_active,
  // Active coefficients of the chosen channel
  output logic [23:0]                 zero_scale_coefficient,
  output logic [23:0]                 full_scale_coefficient
);
  import adc_cal_pkg::*;

  generate
    if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad_channels
      $error("adc_calibration_mode_control: CHANNELS must be 1 to 4");
    end
  endgenerate

  ctl_state_t  s;
  ctl_state_t  next_s;

  op_mode_t    mode;
  logic [1:0]  chan;
  logic        coef_mode;

  logic        zero_we;
  logic        full_we;
  logic [23:0] coef_wdata;
  logic [1:0]  coef_ch;
  logic [23:0] coef_zero;
  logic [23:0] coef_full;

  logic [23:0] rd_word;
  logic        rd_len24;
  logic        wr_valid;
  logic [23:0] wr_data;
  logic        wr_target;
  logic        rd_done;
  logic        rd_target;

  // gain as a power of two
  function automatic logic [7:0] gain_of(input logic [2:0] code);
    return 8'h01 << code;
  endfunction

  function automatic logic is_access(input op_mode_t m);
    return (m == MODE_ZERO_ACCESS) || (m == MODE_FULL_ACCESS);
  endfunction

  // Next measurement for the current mode, step and background slot
  function automatic meas_kind_t pick_kind(input op_mode_t m, input logic step,
                                           input logic [2:0] slot);
    meas_kind_t k;
    k = MEAS_CONVERT;
    case (m)
      MODE_SELF_CAL:   k = step ? MEAS_FULL_REF : MEAS_ZERO_SHORT;
      MODE_SYS_ZERO:   k = MEAS_ZERO_INPUT;
      MODE_SYS_FULL:   k = MEAS_FULL_INPUT;
      MODE_SYS_OFFSET: k = step ? MEAS_FULL_REF : MEAS_ZERO_INPUT;
      MODE_BACKGROUND: begin
        if (slot == `BG_SLOT_FIRST) begin
          k = MEAS_CONVERT;
        end else if (slot[0]) begin
          k = MEAS_ZERO_SHORT;
        end else begin
          k = MEAS_FULL_REF;
        end
      end
      default:         k = MEAS_CONVERT;
    endcase
    return k;
  endfunction

  assign mode      = op_mode_t'(s.cfg[`CFG_MODE_HI:`CFG_MODE_LO]);
  assign chan      = s.cfg[`CFG_CHAN_HI:`CFG_CHAN_LO];
  assign coef_mode = is_access(mode);

  // channel field drives the front end
  assign channel_pick_bit0         = s.cfg[`CFG_CHAN_LO];
  assign channel_pick_bit1         = s.cfg[`CFG_CHAN_HI];
  assign op_mode                   = mode;
  assign programmable_gain_amp     = s.cfg[`CFG_GAIN_HI:`CFG_GAIN_LO];
  assign gain_factor               = gain_of(s.cfg[`CFG_GAIN_HI:`CFG_GAIN_LO]);
  assign output_width_bit          = s.cfg[`CFG_WIDTH_BIT];
  assign excitation_current_enable = s.cfg[`CFG_EXCITE_BIT];
  assign burnout_current_enable    = s.cfg[`CFG_BURNOUT_BIT];
  assign unipolar_select           = s.cfg[`CFG_UNIPOLAR_BIT];
  assign filter_code               = s.cfg[`CFG_FILTER_HI:`CFG_FILTER_LO];
  assign background_active         = (mode == MODE_BACKGROUND);
  assign conversion_ready_n        = s.ready_n;
  assign meas_req                  = (s.st == ST_ISSUE);
  assign meas_kind                 = s.kind;
  assign meas_channel              = s.chan;
  assign zero_scale_coefficient    = coef_zero;
  assign full_scale_coefficient    = coef_full;

  // Read word chosen when the read frame opens
  always_comb begin
    rd_word  = s.cfg;
    rd_len24 = 1'b1;
    if (register_target_select) begin
      case (mode)
        MODE_ZERO_ACCESS: rd_word = coef_zero;
        MODE_FULL_ACCESS: rd_word = coef_full;
        default: begin
          // data word, short form MSB aligned
          rd_word  = s.data_word;
          rd_len24 = s.cfg[`CFG_WIDTH_BIT];
        end
      endcase
    end
  end

  always_comb begin
    next_s     = s;
    zero_we    = 1'b0;
    full_we    = 1'b0;
    coef_wdata = s.result;
    // Ready clears on a complete data read; a new result below wins
    if (rd_done && rd_target && !coef_mode) begin
      next_s.ready_n = 1'b1;
    end
    case (s.st)
      ST_IDLE: begin
        // Access modes hold the converter so coefficients stay put
        if (!coef_mode) begin
          next_s.kind = pick_kind(mode, s.step, s.bg_slot);
          next_s.chan = chan;
          next_s.st   = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        next_s.st = ST_WAIT;
      end
      ST_WAIT: begin
        // Answers outside a wait are ignored
        if (meas_done) begin
          next_s.result = meas_value;
          next_s.st     = ST_STORE;
        end
      end
      ST_STORE: begin
        next_s.st = ST_IDLE;
        case (s.kind)
          MEAS_CONVERT: begin
            next_s.data_word = s.result;
            next_s.ready_n   = 1'b0;
          end
          MEAS_ZERO_SHORT, MEAS_ZERO_INPUT: zero_we = 1'b1;
          MEAS_FULL_INPUT, MEAS_FULL_REF:   full_we = 1'b1;
          default:                          zero_we = 1'b0;
        endcase
        case (mode)
          MODE_SELF_CAL, MODE_SYS_OFFSET: begin
            if (!s.step) begin
              next_s.step = 1'b1;
            end else begin
              next_s.step                          = 1'b0;
              next_s.ready_n                       = 1'b0;
              next_s.cfg[`CFG_MODE_HI:`CFG_MODE_LO] = MODE_NORMAL;
            end
          end
          MODE_SYS_ZERO, MODE_SYS_FULL: begin
            next_s.ready_n                       = 1'b0;
            next_s.cfg[`CFG_MODE_HI:`CFG_MODE_LO] = MODE_NORMAL;
          end
          MODE_BACKGROUND: begin
            if (s.bg_slot == `BG_SLOT_LAST) begin
              next_s.bg_slot = `BG_SLOT_FIRST;
            end else begin
              next_s.bg_slot = s.bg_slot + `BG_SLOT_STEP;
            end
          end
          default: next_s.step = 1'b0;
        endcase
      end
      default: next_s.st = ST_IDLE;
    endcase
    // Last, so a host write beats auto-return
    if (wr_valid) begin
      if (!wr_target) begin
        next_s.cfg     = wr_data;
        next_s.st      = ST_IDLE;
        next_s.step    = 1'b0;
        next_s.bg_slot = `BG_SLOT_FIRST;
      end else if (mode == MODE_ZERO_ACCESS) begin
        zero_we    = 1'b1;
        coef_wdata = wr_data;
      end else if (mode == MODE_FULL_ACCESS) begin
        full_we    = 1'b1;
        coef_wdata = wr_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s           <= '0;
      s.cfg       <= `CFG_RESET;
      s.data_word <= `DATA_RESET;
      s.ready_n   <= 1'b1;
      s.st        <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  cal_serial_port u_serial (
    .clk_sys                (clk_sys),
    .rstn                   (rstn),
    .serial_clk             (serial_clk),
    .write_frame_n          (write_frame_n),
    .read_frame_n           (read_frame_n),
    .register_target_select (register_target_select),
    .serial_data_in         (serial_data_in),
    .serial_data_out        (serial_data_out),
    .serial_data_oe         (serial_data_oe),
    .rd_word                (rd_word),
    .rd_len24               (rd_len24),
    .wr_valid               (wr_valid),
    .wr_data                (wr_data),
    .wr_target              (wr_target),
    .rd_done                (rd_done),
    .rd_target              (rd_target)
  );

  // Results go to the channel measured, host writes to the one picked now
  assign coef_ch = wr_valid ? chan : s.chan;

  cal_coef_store #(
    .CHANNELS (CHANNELS)
  ) u_coef (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .zero_we (zero_we),
    .full_we (full_we),
    .wr_ch   (coef_ch),
    .wr_data (coef_wdata),
    .rd_ch   (chan),
    .rd_zero (coef_zero),
    .rd_full (coef_full)
  );
endmodule

// ---- verification/adc_cal_assertions.sv ----
// Port-level assertions for the calibration and mode control block
`timescale 1ns/10ps
module adc_cal_checker
  import adc_cal_pkg::*;
#(
  parameter int CHANNELS = 3
) (
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rstn,
  // Serial side
  input wire logic                    read_frame_n,
  input wire logic                    serial_data_oe,
  input wire logic                    conversion_ready_n,
  // Measurement core
  input wire logic                    meas_req,
  input wire adc_cal_pkg::meas_kind_t meas_kind,
  input wire logic [1:0]              meas_channel,
  input wire logic                    meas_done,
  input wire logic [23:0]             meas_value,
  // Settings and coefficients
  input wire adc_cal_pkg::op_mode_t   op_mode,
  input wire logic                    channel_pick_bit0,
  input wire logic                    channel_pick_bit1,
  input wire logic [2:0]              programmable_gain_amp,
  input wire logic [7:0]              gain_factor,
  input wire logic                    unipolar_select,
  input wire logic                    background_active,
  input wire logic [23:0]             zero_scale_coefficient
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence back_to_normal;
    ##2 op_mode == MODE_NORMAL && !conversion_ready_n;
  endsequence
  sequence bg_zero_stored;
    meas_done && meas_kind == MEAS_ZERO_SHORT && op_mode == MODE_BACKGROUND
      ##2 op_mode == MODE_BACKGROUND;
  endsequence

  chk_reset_defaults: assert property (
    $rose(rstn) |-> op_mode == MODE_NORMAL && conversion_ready_n && !unipolar_select
      && !channel_pick_bit0 && !channel_pick_bit1 && !serial_data_oe)
    else $error("defaults wrong after reset");
  chk_gain_decode: assert property (
    gain_factor == 8'h01 << programmable_gain_amp)
    else $error("gain factor not a power of two of the code");
  chk_bg_flag: assert property (
    background_active == (op_mode == MODE_BACKGROUND))
    else $error("background flag disagrees with mode");
  chk_meas_channel: assert property (
    meas_req && $stable({channel_pick_bit1, channel_pick_bit0})
      |-> meas_channel == {channel_pick_bit1, channel_pick_bit0})
    else $error("measurement on wrong channel");
  chk_req_single: assert property (
    meas_req |=> !meas_req)
    else $error("request longer than one cycle");
  chk_oe_open: assert property (
    $fell(read_frame_n) |=> serial_data_oe)
    else $error("read data not driven after frame open");
  chk_oe_idle: assert property (
    read_frame_n && $past(read_frame_n) |-> !serial_data_oe)
    else $error("data driven outside read frame");
  chk_full_return: assert property (
    meas_done && op_mode == MODE_SYS_FULL && meas_kind == MEAS_FULL_INPUT
      |-> back_to_normal)
    else $error("full-scale step did not finish");
  chk_offset_mid: assert property (
    meas_done && op_mode == MODE_SYS_OFFSET && meas_kind == MEAS_ZERO_INPUT
      |-> ##2 op_mode == MODE_SYS_OFFSET && !$fell(conversion_ready_n))
    else $error("offset calibration ended after zero step");
  chk_offset_return: assert property (
    meas_done && op_mode == MODE_SYS_OFFSET && meas_kind == MEAS_FULL_REF
      |-> back_to_normal)
    else $error("offset calibration did not finish");
  chk_bg_zero_update: assert property (
    bg_zero_stored |-> {channel_pick_bit1, channel_pick_bit0} == 2'h3
      || zero_scale_coefficient == $past(meas_value, 2))
    else $error("background zero coefficient not updated");
endmodule

// ---- verification/host_serial_model.sv ----
// Host-side serial port model that opens read and write frames
`timescale 1ns/10ps
module host_serial_model (
  // Clock
  input  wire logic clk_sys,
  // Serial pins
  output logic      serial_clk,
  output logic      write_frame_n,
  output logic      read_frame_n,
  output logic      register_target_select,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  initial begin
    serial_clk = 1'b0;
    write_frame_n = 1'b1;
    read_frame_n = 1'b1;
    register_target_select = 1'b0;
    serial_data_in = 1'b0;
  end

  // Two system cycles each phase so every edge is seen
  task automatic pulse_clk();
    serial_clk = 1'b1;
    repeat (2) @(negedge clk_sys);
    serial_clk = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  // the first n bits of the word go out, ~w[0] past bit 24; n sets the clock count
  task automatic write_word(input logic sel, input logic [23:0] w, input int n);
    register_target_select = sel;
    write_frame_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      serial_data_in = (i < 24) ? w[23-i] : ~w[0];
      pulse_clk();
    end
    write_frame_n = 1'b1;
    // Released line must not keep the last bit
    serial_data_in = ~serial_data_in;
    repeat (3) @(negedge clk_sys);
  endtask

  // Bits taken at each rising serial clock, first bit first
  task automatic read_word(input logic sel, input int n, output logic [23:0] v);
    v = 24'h000000;
    register_target_select = sel;
    read_frame_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      v = {v[22:0], serial_data_out};
      pulse_clk();
    end
    read_frame_n = 1'b1;
    repeat (3) @(negedge clk_sys);
  endtask
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the calibration and mode control block
`timescale 1ns/10ps
module tb_top;
  import adc_cal_pkg::*;
  logic        clk_sys, rstn, serial_clk, write_frame_n, read_frame_n;
  logic        register_target_select, serial_data_in, serial_data_out, serial_data_oe;
  logic        conversion_ready_n, meas_req, meas_done, channel_pick_bit0, channel_pick_bit1;
  logic        output_width_bit, excitation_current_enable, burnout_current_enable;
  logic        unipolar_select, background_active;
  meas_kind_t  meas_kind;
  op_mode_t    op_mode;
  logic [1:0]  meas_channel;
  logic [2:0]  programmable_gain_amp, pend;
  logic [7:0]  gain_factor;
  logic [11:0] filter_code;
  logic [23:0] meas_value, zero_scale_coefficient, full_scale_coefficient, cfgv, rd, w;
  int          fails, comparisons, req_n, conv_n, i, r0, c0;

  adc_calibration_mode_control dut_u (.clk_sys, .rstn, .serial_clk, .write_frame_n,
    .read_frame_n, .register_target_select, .serial_data_in, .serial_data_out,
    .serial_data_oe, .conversion_ready_n, .meas_req, .meas_kind, .meas_channel, .meas_done,
    .meas_value, .op_mode, .channel_pick_bit0, .channel_pick_bit1, .programmable_gain_amp,
    .gain_factor, .output_width_bit, .excitation_current_enable, .burnout_current_enable,
    .unipolar_select, .filter_code, .background_active, .zero_scale_coefficient,
    .full_scale_coefficient);
  host_serial_model host_u (.clk_sys, .serial_clk, .write_frame_n, .read_frame_n,
    .register_target_select, .serial_data_in, .serial_data_out);

  assign cfgv = {op_mode, programmable_gain_amp, channel_pick_bit1, channel_pick_bit0,
    output_width_bit, excitation_current_enable, burnout_current_enable, unipolar_select,
    filter_code};

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Result encodes the kind so a wrong store is visible
  function automatic logic [23:0] val(input meas_kind_t k);
    return {k, 21'h0a5c3};
  endfunction
  function automatic logic [23:0] cw(input op_mode_t m, input logic [1:0] ch, input logic wb);
    return {m, 3'h0, ch, wb, 3'h0, 12'h0a5};
  endfunction

  // Core answers each request three cycles later
  always @(negedge clk_sys) begin
    meas_done <= 1'b0;
    meas_value <= ~meas_value;
    if (meas_req === 1'b1) begin
      pend <= 3'h3;
      req_n++;
      if (meas_kind === MEAS_CONVERT) conv_n++;
    end else if (pend == 3'h1) begin
      meas_done <= 1'b1;
      meas_value <= val(meas_kind);
      pend <= 3'h0;
    end else if (pend != 3'h0) pend <= pend - 3'h1;
  end

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("counts: comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic give_up(input string what);
    fails++;
    $display("mismatch %s expected done seen timeout", what);
    close_out();
  endtask
  task automatic wait_mode(input op_mode_t m);
    for (i = 0; i < 500 && op_mode !== m; i++) @(negedge clk_sys);
    if (i == 500) give_up("op_mode");
  endtask

  initial begin
    rstn = 1'b0;
    meas_done = 1'b0;
    meas_value = 24'h000000;
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    check("cfg after reset", 24'h000000, cfgv);
    host_u.read_word(1'b0, 24, rd);
    check("cfg read", 24'h000000, rd);
    for (int g = 0; g < 8; g++) begin
      w = {3'h0, 3'(g), 2'h2, 1'b1, 1'b0, 1'b1, g[0], 12'h0a5};
      host_u.write_word(1'b0, w, 24);
      check("cfg", w, cfgv);
      check("gain", 24'h1 << g, {16'h0, gain_factor});
    end
    host_u.read_word(1'b0, 24, rd);
    check("cfg read", w, rd);
    host_u.write_word(1'b0, 24'h1c0fff, 23);
    check("short cfg", w, cfgv);
    w = {3'h0, 3'h2, 2'h1, 4'h0, 12'h123};
    host_u.write_word(1'b0, w, 26);
    check("long cfg", w, cfgv);
    host_u.write_word(1'b0, cw(MODE_ZERO_ACCESS, 2'h1, 1'b0), 24);
    host_u.write_word(1'b1, 24'h123456, 24);
    check("zero coef", 24'h123456, zero_scale_coefficient);
    host_u.write_word(1'b1, 24'hfedcba, 20);
    check("zero coef short", 24'h123456, zero_scale_coefficient);
    host_u.read_word(1'b1, 24, rd);
    check("zero coef read", 24'h123456, rd);
    host_u.write_word(1'b0, cw(MODE_FULL_ACCESS, 2'h1, 1'b0), 24);
    host_u.write_word(1'b1, 24'h654321, 24);
    host_u.read_word(1'b1, 24, rd);
    check("full coef read", 24'h654321, rd);
    host_u.write_word(1'b0, cw(MODE_SYS_FULL, 2'h1, 1'b0), 24);
    wait_mode(MODE_NORMAL);
    check("full cal", val(MEAS_FULL_INPUT), full_scale_coefficient);
    check("zero kept", 24'h123456, zero_scale_coefficient);
    host_u.write_word(1'b0, cw(MODE_SYS_OFFSET, 2'h2, 1'b0), 24);
    wait_mode(MODE_NORMAL);
    check("offset zero", val(MEAS_ZERO_INPUT), zero_scale_coefficient);
    check("offset full", val(MEAS_FULL_REF), full_scale_coefficient);
    host_u.write_word(1'b0, cw(MODE_BACKGROUND, 2'h0, 1'b0), 24);
    r0 = req_n;
    c0 = conv_n;
    for (i = 0; i < 3000 && req_n - r0 < 12; i++) @(negedge clk_sys);
    if (i == 3000) give_up("requests");
    check("convert share", 24'd2, 24'(conv_n - c0));
    check("bg mode", {21'h0, MODE_BACKGROUND}, {21'h0, op_mode});
    check("bg zero", val(MEAS_ZERO_SHORT), zero_scale_coefficient);
    check("bg full", val(MEAS_FULL_REF), full_scale_coefficient);
    host_u.write_word(1'b0, cw(MODE_NORMAL, 2'h0, 1'b1), 24);
    for (i = 0; i < 500 && conversion_ready_n !== 1'b0; i++) @(negedge clk_sys);
    if (i == 500) give_up("ready");
    host_u.read_word(1'b1, 24, rd);
    check("data 24", val(MEAS_CONVERT), rd);
    host_u.write_word(1'b0, cw(MODE_NORMAL, 2'h0, 1'b0), 24);
    host_u.read_word(1'b1, 16, rd);
    check("data 16", val(MEAS_CONVERT) >> 8, rd);
    close_out();
  end
endmodule

bind adc_calibration_mode_control adc_cal_checker #(.CHANNELS(CHANNELS)) chk_u (.clk_sys,
  .rstn, .read_frame_n, .serial_data_oe, .conversion_ready_n, .meas_req, .meas_kind,
  .meas_channel, .meas_done, .meas_value, .op_mode, .channel_pick_bit0, .channel_pick_bit1,
  .programmable_gain_amp, .gain_factor, .unipolar_select, .background_active,
  .zero_scale_coefficient);
